// >>> cemb_pkg.sv
package cemb_pkg;
  localparam int CEMB_NUM_IN     = 32;
  localparam int CEMB_NUM_LOCAL  = 10;
  localparam int CEMB_NUM_UNIQUE = 9;
  localparam int CEMB_NUM_MC     = 16;
  localparam int CEMB_NUM_FB     = 9;
  localparam int CEMB_ADDR_W     = 11;
  localparam int CEMB_MEM_WORDS  = 2048;
  localparam int CEMB_PAGE_W     = 2;
  localparam int CEMB_DATA_W     = 16;
  localparam int CEMB_PT_IN      = CEMB_NUM_IN + CEMB_NUM_FB;

  typedef enum logic [2:0] {
    CEMB_ORG_128X16  = 3'h0,
    CEMB_ORG_256X8   = 3'h1,
    CEMB_ORG_512X4   = 3'h2,
    CEMB_ORG_1024X2  = 3'h3,
    CEMB_ORG_2048X1  = 3'h4
  } cemb_org_e;

  typedef enum logic [0:0] {
    CEMB_MODE_MEM = 1'h0,
    CEMB_MODE_PT  = 1'h1
  } cemb_mode_e;

  localparam logic [CEMB_NUM_MC-1:0] CEMB_MC_RST = 16'h0000;
endpackage : cemb_pkg

// >>> cemb_mem_if.sv
`timescale 1ns/1ps
interface cemb_mem_if;
  import cemb_pkg::*;
  logic                   we;
  logic [CEMB_ADDR_W-1:0] addr;
  logic                   wbit;
  logic                   rbit;
  modport ctl (output we, output addr, output wbit, input rbit);
  modport mem (input we, input addr, input wbit, output rbit);
endinterface : cemb_mem_if

// >>> cemb_bitram.sv
`timescale 1ns/1ps
module cemb_bitram
  import cemb_pkg::*;
(
  input  wire logic clk_i,
  cemb_mem_if.mem   port_b
);
  logic [CEMB_MEM_WORDS-1:0] mem_ff;
  logic                      rd_ff;

  // Write and registered read at the same edge, read-before-write.
  always_ff @(posedge clk_i) begin
    if (port_b.we) begin
      mem_ff[port_b.addr] <= port_b.wbit;
    end
    rd_ff <= mem_ff[port_b.addr];
  end

  assign port_b.rbit = rd_ff;
endmodule : cemb_bitram

// >>> cemb_block.sv
`timescale 1ns/1ps
module cemb_block
  import cemb_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    mode_i,
  input  wire logic [2:0]              org_i,
  input  wire logic                    page_en_i,
  input  wire logic [CEMB_PAGE_W-1:0]  page_id_i,
  input  wire logic                    page_last_i,
  input  wire logic [CEMB_PAGE_W-1:0]  page_sel_i,
  input  wire logic [CEMB_NUM_IN-1:0]  local_in_i,
  input  wire logic [CEMB_PT_IN-1:0]   pt_and0_mask_i [CEMB_NUM_MC],
  input  wire logic [CEMB_PT_IN-1:0]   pt_and1_mask_i [CEMB_NUM_MC],
  input  wire logic [CEMB_NUM_MC-1:0]  mc_preset_i,
  input  wire logic [CEMB_NUM_MC-1:0]  mc_bypass_i,
  output logic      [CEMB_DATA_W-1:0]  rdata_o,
  output logic      [CEMB_NUM_MC-1:0]  mc_q_o,
  output logic      [CEMB_NUM_LOCAL-1:0] local_out_o,
  output logic                         col_line_o,
  output logic                         col_line_oe_o
);
  // Memory mode input map: [10:0] address, [26:11] write data, [27] write.
  localparam int WD_LSB = CEMB_ADDR_W;
  localparam int WR_BIT = CEMB_ADDR_W + CEMB_DATA_W;

  logic [CEMB_ADDR_W-1:0]  addr_w;
  logic [CEMB_DATA_W-1:0]  wdata_w;
  logic                    wreq_w;
  logic [3:0]              lanes_log2_w;
  logic [CEMB_DATA_W-1:0]  rbits_w;
  logic [CEMB_ADDR_W-1:0]  sel_ff;
  logic [2:0]              org_ff;
  logic [CEMB_PAGE_W-1:0]  page_ff;
  logic [CEMB_NUM_MC-1:0]  mc_ff;
  logic [CEMB_NUM_MC-1:0]  nxt_mc;
  logic [CEMB_NUM_MC-1:0]  mc_comb_w;
  logic [CEMB_PT_IN-1:0]   pt_in_w;
  logic [CEMB_DATA_W-1:0]  rd_word_w;
  logic                    page_hit_w;

  assign addr_w  = local_in_i[CEMB_ADDR_W-1:0];
  assign wdata_w = local_in_i[WR_BIT-1:WD_LSB];
  assign wreq_w  = local_in_i[WR_BIT] && (mode_i == CEMB_MODE_MEM);

  // Lanes in use: 16 >> org; each lane is a 2048x1 column.
  function automatic logic [3:0] org_shift(input logic [2:0] org);
    case (org)
      CEMB_ORG_128X16: org_shift = 4'h4;
      CEMB_ORG_256X8:  org_shift = 4'h3;
      CEMB_ORG_512X4:  org_shift = 4'h2;
      CEMB_ORG_1024X2: org_shift = 4'h1;
      default:         org_shift = 4'h0;
    endcase
  endfunction : org_shift

  assign lanes_log2_w = org_shift(org_i);

  // Word w of width W sits in lane (w*W + k) mod 16 at row (w*W+k)/16.
  genvar g;
  generate
    for (g = 0; g < CEMB_DATA_W; g++) begin : g_lane
      cemb_mem_if lane_if ();
      logic [14:0] lin_w;
      logic [3:0]  bit_w;
      assign lin_w = (15'(addr_w) << lanes_log2_w);
      assign bit_w = 4'(g) & ((4'h1 << lanes_log2_w) - 4'h1);
      // Lane g holds flat bit lin + bit_w; row is that index over 16.
      assign lane_if.addr = 11'((lin_w + 15'(bit_w)) >> 4);
      // Strobe made here from request input bit 27 in memory mode, not by user logic.
      // The lane match alone picks the one lane that stores each bit.
      assign lane_if.we = wreq_w &&
        (4'((lin_w + 15'(bit_w))) == 4'(g));
      assign lane_if.wbit = wdata_w[bit_w];
      assign rbits_w[g] = lane_if.rbit;
      cemb_bitram u_ram (
        .clk_i  (clk_i),
        .port_b (lane_if.mem)
      );
    end
  endgenerate

  // Capture the read select so the unpack matches the registered data.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_ff  <= '0;
      org_ff  <= 3'h4;
      page_ff <= '0;
    end else begin
      sel_ff  <= addr_w;
      org_ff  <= org_i;
      page_ff <= page_sel_i;
    end
  end

  always_comb begin
    logic [3:0]  sh;
    logic [14:0] lin;
    sh  = org_shift(org_ff);
    lin = 15'(sel_ff) << sh;
    rd_word_w = '0;
    for (int k = 0; k < CEMB_DATA_W; k++) begin
      if ((k >> sh) == 0 || sh == 4'h4) begin
        rd_word_w[k] = rbits_w[4'(lin + 15'(k))];
      end
    end
  end

  // Preset-type cells are stored inverted, so the constant clear reads
  // back as set. Changing mc_preset_i while running flips the held state.
  logic [CEMB_NUM_MC-1:0] mc_q_w;
  assign mc_q_w = mc_ff ^ mc_preset_i;

  // Product terms see the 32 inputs plus nine macrocell feedbacks.
  assign pt_in_w = {mc_q_w[CEMB_NUM_FB-1:0], local_in_i};

  always_comb begin
    for (int m = 0; m < CEMB_NUM_MC; m++) begin
      mc_comb_w[m] =
        (&(pt_in_w | ~pt_and0_mask_i[m])) |
        (&(pt_in_w | ~pt_and1_mask_i[m]));
      nxt_mc[m] = mc_comb_w[m] ^ mc_preset_i[m];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mc_ff <= CEMB_MC_RST;
    end else if (mode_i == CEMB_MODE_PT) begin
      mc_ff <= nxt_mc;
    end
  end

  assign mc_q_o = (mc_bypass_i & mc_comb_w) | (~mc_bypass_i & mc_q_w);

  assign rdata_o = rd_word_w;

  // Decoder: this block owns page page_id_i of the shared column.
  assign page_hit_w = page_en_i && (page_ff == page_id_i);
  // Exactly one block per column is marked last and holds the line
  // while page_en_i is low; with paging on and no page matching, nothing drives it.
  assign col_line_oe_o = page_hit_w ||
    (page_last_i && !page_en_i);
  assign col_line_o = col_line_oe_o ? rd_word_w[0] : 1'b0;

  // Nine unique local lines plus bit 0 repeated as the tenth.
  assign local_out_o = (mode_i == CEMB_MODE_PT) ?
    {mc_q_o[0], mc_q_o[CEMB_NUM_UNIQUE-1:0]} :
    {rd_word_w[0], rd_word_w[CEMB_NUM_UNIQUE-1:0]};
endmodule : cemb_block

// >>> cemb_cell_model.sv
`timescale 1ns/1ps
module cemb_cell_model
  import cemb_pkg::*;
(
  input  wire logic                   we_i,
  input  wire logic [CEMB_ADDR_W-1:0] addr_i,
  input  wire logic [CEMB_DATA_W-1:0] wdata_i,
  output logic      [CEMB_NUM_IN-1:0] local_o
);
  // Cells only present address, data and request; the strobe is not ours.
  assign local_o = {4'h0, we_i, wdata_i, addr_i};
endmodule : cemb_cell_model

// >>> cemb_block_props.sv
`timescale 1ns/1ps
module cemb_block_props
  import cemb_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        mode_i,
  input wire logic [2:0]  org_i,
  input wire logic        page_en_i,
  input wire logic [1:0]  page_id_i,
  input wire logic        page_last_i,
  input wire logic [1:0]  page_sel_i,
  input wire logic [31:0] local_in_i,
  input wire logic [15:0] rdata_o,
  input wire logic [9:0]  local_out_o,
  input wire logic        col_line_o,
  input wire logic        col_line_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire mem_rd = mode_i == CEMB_MODE_MEM && !local_in_i[27];
  wire mem_wr = mode_i == CEMB_MODE_MEM && local_in_i[27];
  wire pg_on = page_en_i && mode_i == CEMB_MODE_MEM;
  AST_DUP_OUT: assert property (local_out_o[9] == local_out_o[0])
    else $error("duplicate local output differs");
  AST_RD_HOLD: assert property (mem_rd ##1 (mem_rd && $stable(local_in_i)
    && $stable(org_i)) |=> $stable(rdata_o))
    else $error("read word moved without a cause");
  AST_WR_RD: assert property ((mem_wr && org_i == 3'h0) ##1 (mem_rd
    && org_i == 3'h0 && $stable(local_in_i[10:0]))
    |=> rdata_o == $past(local_in_i[26:11], 2))
    else $error("written word not read back");
  AST_PT_NO_WR: assert property ((mem_rd && $stable(org_i)) ##1
    (mode_i && $stable(local_in_i[10:0]) && $stable(org_i)) ##1
    (mem_rd && $stable(local_in_i[10:0]) && $stable(org_i))
    |=> rdata_o == $past(rdata_o, 2))
    else $error("write accepted in product-term mode");
  AST_PAGE_ON: assert property ((pg_on && page_sel_i == page_id_i) ##1
    (pg_on && $stable(page_id_i)) |-> col_line_oe_o)
    else $error("selected page does not drive");
  AST_PAGE_OFF: assert property ((pg_on && page_sel_i != page_id_i
    && !page_last_i) ##1 (pg_on && $stable(page_id_i) && !page_last_i)
    |-> !col_line_oe_o)
    else $error("unselected page drives");
  AST_PAGE_HOLD: assert property (pg_on ##1 (pg_on && $stable(page_sel_i)
    && $stable(page_id_i) && $stable(page_last_i))
    |=> ($stable(page_en_i) && $stable(page_id_i) && $stable(page_last_i))
    |-> $stable(col_line_oe_o))
    else $error("line enable glitches");
  AST_COL_DATA: assert property (col_line_oe_o |-> col_line_o == rdata_o[0])
    else $error("column line data wrong");
endmodule : cemb_block_props
bind cemb_block cemb_block_props i_cemb_block_props (.*);

// >>> cemb_block_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module cemb_block_tb;
  import cemb_pkg::*;
  logic clk_i = 1'b0, resetn_i = 1'b0, mode_i = 1'b1, we = 1'b0;
  logic [2:0] org_i = 3'h0;
  logic page_en_i = 1'b0, page_last_i = 1'b0;
  logic [1:0] page_id_i = 2'h0, page_sel_i = 2'h0;
  logic [10:0] addr = 11'h000;
  logic [15:0] wdata = 16'h0000, mc_preset_i = 16'h00F0, rdata_o, mc_q_o;
  logic [31:0] local_in_i;
  logic [CEMB_PT_IN-1:0] pt_mask [CEMB_NUM_MC] = '{default: '0};
  logic [9:0] local_out_o;
  logic col_line_o, col_line_oe_o;
  int n_errors = 0, n_tests = 0;
  localparam logic [31:0] ROWS [5] = '{32'h007FA5C3, 32'h10FF00B6,
    32'h21FF0009, 32'h33FF0002, 32'h47FF0001};
  always #4 clk_i = ~clk_i;
  cemb_cell_model i_cemb_cell_model (.we_i(we), .addr_i(addr),
    .wdata_i(wdata), .local_o(local_in_i));
  cemb_block i_cemb_block (.clk_i(clk_i), .resetn_i(resetn_i),
    .mode_i(mode_i), .org_i(org_i), .page_en_i(page_en_i),
    .page_id_i(page_id_i), .page_last_i(page_last_i),
    .page_sel_i(page_sel_i), .local_in_i(local_in_i),
    .pt_and0_mask_i(pt_mask), .pt_and1_mask_i(pt_mask),
    .mc_preset_i(mc_preset_i), .mc_bypass_i(16'h0000), .rdata_o(rdata_o),
    .mc_q_o(mc_q_o), .local_out_o(local_out_o), .col_line_o(col_line_o),
    .col_line_oe_o(col_line_oe_o));
  task automatic access(input logic [10:0] a, input logic [15:0] d,
                        input logic w);
    addr = a;
    wdata = d;
    we = w;
    @(negedge clk_i);
    we = 1'b0;
    @(negedge clk_i);
  endtask : access
  task automatic finish_test();
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(negedge clk_i);
    `CHK(mc_q_o, 16'h00F0)
    resetn_i = 1'b1;
    mode_i = CEMB_MODE_MEM;
    foreach (ROWS[i]) begin
      org_i = ROWS[i][30:28];
      access(ROWS[i][26:16], ROWS[i][15:0], 1'b1);
      `CHK(rdata_o & 16'(16'hFFFF >> (16 - (16 >> org_i))), ROWS[i][15:0])
    end
    org_i = 3'h0;
    access(11'h000, 16'h1234, 1'b1);
    mode_i = CEMB_MODE_PT;
    wdata = 16'hFFFF;
    we = 1'b1;
    @(negedge clk_i);
    mode_i = CEMB_MODE_MEM;
    we = 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK(rdata_o, 16'h1234)
    `CHK(local_out_o[9], local_out_o[0])
    page_en_i = 1'b1;
    page_id_i = 2'h2;
    page_sel_i = 2'h2;
    repeat (2) @(negedge clk_i);
    `CHK(col_line_oe_o, 1'b1)
    `CHK(col_line_o, rdata_o[0])
    page_sel_i = 2'h1;
    repeat (2) @(negedge clk_i);
    `CHK(col_line_oe_o, 1'b0)
    mode_i = CEMB_MODE_PT;
    @(negedge clk_i);
    `CHK(mc_q_o, 16'hFFFF)
    `CHK(local_out_o, 10'h3FF)
    resetn_i = 1'b0;
    @(negedge clk_i);
    `CHK(mc_q_o, 16'h00F0)
    finish_test();
  end
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule : cemb_block_tb
